// ==== core/scrd_decoder.sv ====
// SMBus slave that decodes configuration read set-up and read back
`timescale 1ns/10ps
`include "scrd_defs.svh"

// Contract
// - Block Write code BAh loads read parameters
// - Set-up count 04h, four command bytes
// - First byte bits 2:0 select write/read
// - Port selector from byte2[3:0] and byte3[7]
// - Access routed to selected port 0-5
// - Byte3 bits 5:2 are byte enables
// - Enabled bytes modifiable, others kept unchanged
// - Address from byte3[1:0] and byte4, dword aligned
// - Code BDh then repeated start returns register
// - Data bytes returned most significant first
// - Set-up and read are separate transfers
// - Receiver drives ack low, nack high
// - Default slave address 1101000b after reset
// - Nack malformed sequence from first bad byte
// - Extra byte after data is PEC; sent on reads only, a byte after the four command bytes is nacked as bad
// - Master nack ends read, releases data
// - Read response starts with count 04h
module scrd_decoder
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // SMBus pins; enables are low while driving
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  // Slave address control
  input  wire logic [6:0]  slave_addr_new,
  input  wire logic        slave_addr_load,
  // Register access toward the ports
  output logic             cfg_req,
  output logic             cfg_we,
  output logic [4:0]       cfg_port,
  output logic [3:0]       cfg_be,
  output logic [11:0]      cfg_addr,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_ack,
  // Status
  output logic             setup_valid,
  output logic             seq_error
);
  // ---------------------------------------------------------------
  // Pin conditioning and bus events
  // ---------------------------------------------------------------
  logic scl;
  logic sda;
  logic scl_q;
  logic sda_q;

  scrd_pin_sync u_scl (.ref_clk(ref_clk), .rst(rst), .pin(scl_in),
                       .level(scl));
  scrd_pin_sync u_sda (.ref_clk(ref_clk), .rst(rst), .pin(sda_in),
                       .level(sda));

  always_ff @(posedge ref_clk)
    if (rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
    end

  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_ev = scl & scl_q & sda_q & ~sda;
  wire stop_ev  = scl & scl_q & ~sda_q & sda;

  // ---------------------------------------------------------------
  // Byte framing state
  // ---------------------------------------------------------------
  scrd_pkg::scrd_state_t st_q;
  scrd_pkg::scrd_tx_t    tx_q;
  logic [6:0]  my_addr_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q;
  logic [3:0]  idx_q;
  logic        is_setup_q;
  logic        is_read_q;
  logic        nack_q;
  logic        ack_phase_q;
  logic [7:0]  cb1_q;
  logic [7:0]  cb2_q;
  logic [7:0]  cb3_q;
  logic [31:0] rdata_q;
  logic [1:0]  dcnt_q;
  logic [7:0]  pec_q;
  logic        mack_q;

  // CRC-8 step, polynomial x^8+x^2+x+1, used for each byte on the bus
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    return r;
  endfunction

  // Byte presented to the master for the current transmit slot
  function automatic logic [7:0] tx_byte(input scrd_pkg::scrd_tx_t t,
                                         input logic [31:0] d,
                                         input logic [1:0] n,
                                         input logic [7:0] p);
    unique case (t)
      scrd_pkg::SCRD_TX_CNT:  return `SCRD_READ_COUNT;
      scrd_pkg::SCRD_TX_DATA: return d[8'(31 - 8 * n) -: 8];
      scrd_pkg::SCRD_TX_PEC:  return p;
      scrd_pkg::SCRD_TX_NONE: return 8'hff;
    endcase
  endfunction

  // Check one received byte of a write transfer; idx counts from 0
  function automatic logic byte_ok(input logic [3:0] i,
                                   input logic [7:0] b,
                                   input logic       setup);
    if (i == 4'h0)
      return (b == `SCRD_CMD_SETUP) || (b == `SCRD_CMD_READ);
    if (!setup)
      return 1'b0;
    if (i == 4'h1)
      return b == `SCRD_SETUP_COUNT;
    if (i == 4'h2)
      return b[2:0] == `SCRD_OP_READ || b[2:0] == `SCRD_OP_WRITE;
    return i <= 4'h4 || i == 4'h5;
  endfunction

  // Slave address, software may reprogram it
  always_ff @(posedge ref_clk)
    if (rst)
      my_addr_q <= `SCRD_ADDR_DEFAULT;
    else if (slave_addr_load)
      my_addr_q <= slave_addr_new;

  wire [7:0] rx_byte = sh_q;
  wire       byte_done = scl_rise && bit_q == 4'h7;

  always_ff @(posedge ref_clk)
    if (rst)
    begin
      st_q        <= scrd_pkg::SCRD_IDLE;
      tx_q        <= scrd_pkg::SCRD_TX_NONE;
      bit_q       <= 4'h0;
      sh_q        <= 8'h00;
      idx_q       <= 4'h0;
      is_setup_q  <= 1'b0;
      is_read_q   <= 1'b0;
      nack_q      <= 1'b0;
      ack_phase_q <= 1'b0;
      dcnt_q      <= 2'h0;
      pec_q       <= 8'h00;
      mack_q      <= 1'b0;
      seq_error   <= 1'b0;
    end
    else if (start_ev)
    begin
      st_q        <= scrd_pkg::SCRD_ADDR;
      bit_q       <= 4'h0;
      ack_phase_q <= 1'b0;
      nack_q      <= 1'b0;
      tx_q        <= scrd_pkg::SCRD_TX_NONE;
      pec_q       <= 8'h00;
    end
    else if (stop_ev)
    begin
      st_q      <= scrd_pkg::SCRD_IDLE;
      idx_q     <= 4'h0;
      is_read_q <= 1'b0;
      tx_q      <= scrd_pkg::SCRD_TX_NONE;
    end
    else if (st_q != scrd_pkg::SCRD_IDLE && st_q != scrd_pkg::SCRD_IGN)
    begin
      if (!ack_phase_q && scl_rise)
      begin
        sh_q  <= {sh_q[6:0], sda};
        bit_q <= bit_q + 4'h1;
      end
      if (!ack_phase_q && byte_done)
      begin
        if (st_q == scrd_pkg::SCRD_SEND)
          pec_q <= crc8(pec_q, tx_byte(tx_q, rdata_q, dcnt_q, pec_q));
        else
          pec_q <= crc8(pec_q, {sh_q[6:0], sda});
      end
      if (!ack_phase_q && scl_fall && bit_q == 4'h8)
      begin
        ack_phase_q <= 1'b1;
        bit_q       <= 4'h0;
        unique case (st_q)
          scrd_pkg::SCRD_ADDR:
            if (rx_byte[7:1] != my_addr_q)
              st_q <= scrd_pkg::SCRD_IGN;
            else if (rx_byte[0])
            begin
              nack_q <= ~is_read_q;
              tx_q   <= scrd_pkg::SCRD_TX_CNT;
            end
            else
            begin
              nack_q <= 1'b0;
              idx_q  <= 4'h0;
            end
          scrd_pkg::SCRD_RECV:
          begin
            nack_q <= nack_q | ~byte_ok(idx_q, rx_byte, is_setup_q);
            seq_error <= seq_error | ~byte_ok(idx_q, rx_byte, is_setup_q);
            if (idx_q == 4'h0)
            begin
              is_setup_q <= rx_byte == `SCRD_CMD_SETUP;
              is_read_q  <= rx_byte == `SCRD_CMD_READ;
            end
            idx_q <= idx_q + 4'h1;
          end
          scrd_pkg::SCRD_SEND:
            mack_q <= 1'b0;
          default:
            st_q <= scrd_pkg::SCRD_IGN;
        endcase
      end
      else if (ack_phase_q && scl_rise && st_q == scrd_pkg::SCRD_SEND)
        mack_q <= sda;
      else if (ack_phase_q && scl_fall)
      begin
        ack_phase_q <= 1'b0;
        if (nack_q)
          st_q <= scrd_pkg::SCRD_IGN;
        else if (st_q == scrd_pkg::SCRD_ADDR)
          st_q <= tx_q == scrd_pkg::SCRD_TX_CNT ? scrd_pkg::SCRD_SEND
                                                : scrd_pkg::SCRD_RECV;
        else if (st_q == scrd_pkg::SCRD_SEND)
        begin
          if (mack_q)
          begin
            st_q <= scrd_pkg::SCRD_IGN;
            tx_q <= scrd_pkg::SCRD_TX_NONE;
          end
          else if (tx_q == scrd_pkg::SCRD_TX_CNT)
          begin
            tx_q   <= scrd_pkg::SCRD_TX_DATA;
            dcnt_q <= 2'h0;
          end
          else if (tx_q == scrd_pkg::SCRD_TX_DATA && dcnt_q == 2'h3)
            tx_q <= scrd_pkg::SCRD_TX_PEC;
          else if (tx_q == scrd_pkg::SCRD_TX_DATA)
            dcnt_q <= dcnt_q + 2'h1;
          else
            tx_q <= scrd_pkg::SCRD_TX_NONE;
        end
      end
    end

  // ---------------------------------------------------------------
  // Command byte capture and decoded set-up
  // ---------------------------------------------------------------
  wire rx_take = st_q == scrd_pkg::SCRD_RECV && !ack_phase_q &&
                 scl_fall && bit_q == 4'h8 && is_setup_q &&
                 byte_ok(idx_q, rx_byte, is_setup_q) && !nack_q;

  always_ff @(posedge ref_clk)
    if (rst)
    begin
      cb1_q <= 8'h00;
      cb2_q <= 8'h00;
      cb3_q <= 8'h00;
    end
    else if (rx_take)
    begin
      if (idx_q == 4'h2)
        cb1_q <= rx_byte;
      if (idx_q == 4'h3)
        cb2_q <= rx_byte;
      if (idx_q == 4'h4)
        cb3_q <= rx_byte;
    end

  // Parameters latch on a good fourth command byte; setup_valid sets at the stop after it only if cfg_port is 0-5
  logic load_pend_q;

  always_ff @(posedge ref_clk)
    if (rst)
    begin
      cfg_we      <= 1'b0;
      cfg_port    <= 5'h00;
      cfg_be      <= 4'h0;
      cfg_addr    <= 12'h000;
      setup_valid <= 1'b0;
      load_pend_q <= 1'b0;
    end
    else if (rx_take && idx_q == 4'h5)
    begin
      // Reserved bits 7:3, 7:4 and 6 are never looked at
      cfg_we   <= cb1_q[2:0] == `SCRD_OP_WRITE;
      cfg_port <= {cb2_q[3:0], cb3_q[`SCRD_PSEL_LO_BIT]};
      cfg_be   <= cb3_q[5:`SCRD_BE_LSB];
      cfg_addr <= {cb3_q[1:0], rx_byte, 2'b00};
      setup_valid <= 1'b0;
      load_pend_q <= 1'b1;
    end
    else if (stop_ev && load_pend_q)
    begin
      setup_valid <= cfg_port <= `SCRD_PORT_MAX;
      load_pend_q <= 1'b0;
    end
    else if (start_ev)
      load_pend_q <= 1'b0;

  // Fetch happens when the read code arrives with setup_valid set; data held until next fetch
  logic fetch_q;

  always_ff @(posedge ref_clk)
    if (rst)
    begin
      cfg_req <= 1'b0;
      fetch_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      cfg_req <= 1'b0;
      if (st_q == scrd_pkg::SCRD_RECV && scl_fall && !ack_phase_q &&
          bit_q == 4'h8 && idx_q == 4'h0 &&
          rx_byte == `SCRD_CMD_READ && setup_valid && !fetch_q)
      begin
        cfg_req <= 1'b1;
        fetch_q <= 1'b1;
      end
      else if (fetch_q && cfg_ack)
      begin
        rdata_q <= cfg_rdata;
        fetch_q <= 1'b0;
      end
    end

  // ---------------------------------------------------------------
  // Data line drive; the pin is open drain, only a low is driven
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
    if (rst)
    begin
      sda_out  <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else if (st_q == scrd_pkg::SCRD_IDLE || st_q == scrd_pkg::SCRD_IGN
             || start_ev || stop_ev)
    begin
      sda_out  <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else if (ack_phase_q && st_q != scrd_pkg::SCRD_SEND)
    begin
      sda_out  <= 1'b0;
      sda_oe_n <= nack_q;
    end
    else if (st_q == scrd_pkg::SCRD_SEND && !ack_phase_q && scl)
    begin
      // Data may only move with the clock low, else it fakes a start or stop
      sda_out  <= sda_out;
      sda_oe_n <= sda_oe_n;
    end
    else if (st_q == scrd_pkg::SCRD_SEND && !ack_phase_q &&
             bit_q < 4'h8 && tx_q != scrd_pkg::SCRD_TX_NONE)
    begin
      sda_out  <= 1'b0;
      sda_oe_n <= tx_byte(tx_q, rdata_q, dcnt_q, pec_q)[3'(7 - bit_q)];
    end
    else
    begin
      sda_out  <= 1'b1;
      sda_oe_n <= 1'b1;
    end
endmodule

// ==== core/scrd_defs.svh ====
// Constants for the SMBus configuration read decoder
`ifndef SCRD_DEFS_SVH
`define SCRD_DEFS_SVH
`define SCRD_ADDR_DEFAULT  7'h68
`define SCRD_CMD_SETUP     8'hba
`define SCRD_CMD_READ      8'hbd
`define SCRD_SETUP_COUNT   8'h04
`define SCRD_READ_COUNT    8'h04
`define SCRD_OP_WRITE      3'h3
`define SCRD_OP_READ       3'h4
`define SCRD_OP_LSB        0
`define SCRD_PSEL_HI_LSB   0
`define SCRD_PSEL_LO_BIT   7
`define SCRD_BE_LSB        2
`define SCRD_ADDR_HI_LSB   0
`define SCRD_PORT_MAX      5'h05
`endif

// ==== core/scrd_pkg.sv ====
// Types for the SMBus configuration read decoder
package scrd_pkg;
  typedef enum logic [2:0] {
    SCRD_IDLE  = 3'b000,
    SCRD_ADDR  = 3'b001,
    SCRD_RECV  = 3'b010,
    SCRD_SEND  = 3'b011,
    SCRD_IGN   = 3'b100
  } scrd_state_t;
  typedef enum logic [1:0] {
    SCRD_TX_NONE = 2'b00,
    SCRD_TX_CNT  = 2'b01,
    SCRD_TX_DATA = 2'b10,
    SCRD_TX_PEC  = 2'b11
  } scrd_tx_t;
endpackage

// ==== core/scrd_pin_sync.sv ====
// Pin synchroniser with two-stage agreement filter
`timescale 1ns/10ps
module scrd_pin_sync
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Pin and filtered level
  input  wire logic pin,
  output logic      level
);
  logic [2:0] sh_q;

  // ---------------------------------------------------------------
  // Three flops; level moves only when stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
    if (rst)
      sh_q <= 3'h7;
    else
      sh_q <= {sh_q[1:0], pin};

  always_ff @(posedge ref_clk)
    if (rst)
      level <= 1'b1;
    else if (sh_q[1] == sh_q[2])
      level <= sh_q[2];
endmodule

// ==== test/scrd_decoder_checker.sv ====
// Assertions on the decoder ports
`timescale 1ns/10ps
module scrd_decoder_checker
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Bus side
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  // Register side
  input wire logic       cfg_req,
  input wire logic [4:0] cfg_port,
  input wire logic       setup_valid,
  input wire logic       seq_error
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  drive_zero_a: assert property (!sda_oe_n |-> !sda_out)
    else $error("data driven high");
  port_range_a: assert property (setup_valid |-> cfg_port <= 5'h05)
    else $error("port out of range");
  req_pulse_a: assert property (cfg_req |=> !cfg_req)
    else $error("fetch longer than one cycle");
  req_setup_a: assert property (cfg_req |-> setup_valid)
    else $error("fetch without set-up");
  commit_stop_a: assert property ($rose(setup_valid) |-> scl_in)
    else $error("set-up committed off a stop");
  err_sticky_a: assert property (seq_error |=> seq_error)
    else $error("error flag dropped");
  // A malformed byte must see its slot left high
  err_nack_a: assert property ($rose(seq_error) |-> sda_oe_n [*8])
    else $error("bad byte acknowledged");
  // Drive changes with clock high would fake a start or stop
  drive_edge_a: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("drive changed with clock high");
endmodule
bind scrd_decoder scrd_decoder_checker i_chk (.ref_clk(ref_clk),
  .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .cfg_req(cfg_req), .cfg_port(cfg_port), .setup_valid(setup_valid),
  .seq_error(seq_error));

// ==== test/scrd_master_model.sv ====
// Bus master model driving the SMBus lines
`timescale 1ns/10ps
module scrd_master_model
#(
  parameter int HALF = 20
)
(
  // Clock
  input wire logic ref_clk,
  // Bus lines; released lines float to the pull-up
  input wire logic sda,
  output logic     scl,
  output logic     sda_lo
);
  initial
  begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end
  task automatic tick();
    repeat (HALF) @(negedge ref_clk);
  endtask
  // Start or repeated start; clock stands high between frames
  task automatic start();
    sda_lo = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_lo = 1'b1;
    tick();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_lo = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_lo = 1'b0;
    tick();
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_lo = !b;
    tick();
    scl = 1'b1;
    repeat (HALF / 2) @(negedge ref_clk);
    s = sda;
    repeat (HALF / 2) @(negedge ref_clk);
    scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic rbyte(input logic nak, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(nak, s);
  endtask
endmodule

// ==== test/test_scrd_decoder.sv ====
// Self-checking bench for the configuration read decoder
`timescale 1ns/10ps
module test_scrd_decoder;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        scl, sda_lo, sda_out, sda_oe_n, sda, ack;
  logic [6:0]  slave_addr_new = 7'h68;
  logic        slave_addr_load = 1'b0;
  logic        cfg_req, cfg_we, setup_valid, seq_error;
  logic        cfg_ack = 1'b0;
  logic [4:0]  cfg_port;
  logic [3:0]  cfg_be;
  logic [11:0] cfg_addr;
  logic [31:0] cfg_rdata = 32'h0;
  logic [7:0]  b, pec;
  int          mismatches = 0;
  int          total_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  // Open-drain data wire with pull-up
  assign sda = !sda_lo && (sda_oe_n || sda_out);
  // Port logic answers each fetch a cycle later
  always @(negedge ref_clk)
    cfg_ack <= cfg_req;
  scrd_decoder i_dut (.ref_clk(ref_clk), .rst(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .slave_addr_new(slave_addr_new), .slave_addr_load(slave_addr_load),
    .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_port(cfg_port),
    .cfg_be(cfg_be), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .setup_valid(setup_valid), .seq_error(seq_error));
  scrd_master_model i_mst (.ref_clk(ref_clk), .sda(sda), .scl(scl),
    .sda_lo(sda_lo));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    c = c ^ d;
    for (int i = 0; i < 8; i++)
      c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction
  task automatic wr(input logic [7:0] d, input logic exp_ack);
    i_mst.wbyte(d, ack);
    chk(ack, exp_ack);
  endtask
  task automatic setup(input logic [31:0] cb);
    i_mst.start();
    wr(8'hd0, 1'b1);
    wr(8'hba, 1'b1);
    wr(8'h04, 1'b1);
    for (int i = 3; i >= 0; i--)
      wr(cb[i*8 +: 8], 1'b1);
    i_mst.stop();
  endtask
  task automatic read_back(input logic [31:0] v);
    logic [39:0] exp;
    exp = {8'h04, v};
    cfg_rdata = v;
    pec = crc8(8'h00, 8'hd1);
    i_mst.start();
    wr(8'hd0, 1'b1);
    wr(8'hbd, 1'b1);
    i_mst.start();
    wr(8'hd1, 1'b1);
    for (int i = 4; i >= 0; i--)
    begin
      i_mst.rbyte(1'b0, b);
      chk(b, exp[i*8 +: 8]);
      pec = crc8(pec, exp[i*8 +: 8]);
    end
    i_mst.rbyte(1'b1, b);
    chk(b, pec);
    i_mst.stop();
    chk(sda_oe_n, 1'b1);
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    wrap_up();
  end
  initial
  begin
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({setup_valid, seq_error}, 2'h0);
    // Read of port 1, dword f8h, all bytes enabled
    setup(32'h0400_bc3e);
    chk({cfg_we, cfg_port, cfg_be, cfg_addr}, 22'h01_f0f8);
    chk(setup_valid, 1'b1);
    read_back(32'h1234_5678);
    read_back(32'ha55a_0ff0);
    // Master nack on the first data byte ends the read early
    i_mst.start();
    wr(8'hd0, 1'b1);
    wr(8'hbd, 1'b1);
    i_mst.start();
    wr(8'hd1, 1'b1);
    i_mst.rbyte(1'b0, b);
    chk(b, 8'h04);
    i_mst.rbyte(1'b1, b);
    chk(b, 8'ha5);
    repeat (20) @(negedge ref_clk);
    chk(sda, 1'b1);
    i_mst.stop();
    // Write op to port 5, partial enables, reserved bits set
    setup(32'hfbf2_d6ff);
    chk({cfg_we, cfg_port, cfg_be, cfg_addr}, 22'h25_5bfc);
    i_mst.start();
    wr(8'hd2, 1'b0);
    i_mst.stop();
    slave_addr_new = 7'h2a;
    slave_addr_load = 1'b1;
    @(negedge ref_clk);
    slave_addr_load = 1'b0;
    i_mst.start();
    wr(8'h54, 1'b1);
    i_mst.stop();
    i_mst.start();
    wr(8'h55, 1'b0);
    i_mst.stop();
    chk(seq_error, 1'b0);
    i_mst.start();
    wr(8'h54, 1'b1);
    wr(8'hba, 1'b1);
    wr(8'h05, 1'b0);
    wr(8'h04, 1'b0);
    i_mst.stop();
    chk(seq_error, 1'b1);
    wrap_up();
  end
endmodule
